// [logic/psm_pkg.sv]
// Purpose: shared constants for the program space read mapper
// Assumes: 16-bit data space, 24-bit program words
// Notes:   register offsets are byte addresses on the ahb-lite slave
package psm_pkg;
   localparam logic [7:0]  OFF_TBL_PAGE = 8'h00;
   localparam logic [7:0]  OFF_RDPAG    = 8'h04;
   localparam logic [7:0]  OFF_STATUS   = 8'h08;
   localparam logic [7:0]  OFF_MASK     = 8'h0C;
   localparam logic [7:0]  OFF_LASTADDR = 8'h10;
   localparam logic [7:0]  OFF_LASTDATA = 8'h14;
   localparam logic [7:0]  OFF_CYCLES   = 8'h18;
   localparam logic [7:0]  TBL_PAGE_RST = 8'h00;
   localparam logic [9:0]  RDPAG_RST    = 10'h001;
   localparam int          TBL_CFG_BIT  = 7;
   localparam int          RD_EN_BIT    = 9;
   localparam int          RD_HI_BIT    = 8;
   localparam logic [15:0] WIN_BASE     = 16'h8000;
   localparam int          ST_ADDRERR   = 0;
   localparam int          ST_CFGWR     = 1;
   localparam int          ST_DONE      = 2;
   localparam int          NUM_EVT      = 3;
   localparam logic [1:0]  XTRA_MOV     = 2'h1;
   localparam logic [1:0]  XTRA_OTHER   = 2'h2;
   localparam logic [1:0]  XTRA_NONE    = 2'h0;
   typedef enum logic [1:0] {
      ACC_TBL_LO,
      ACC_TBL_HI,
      ACC_DATA,
      ACC_TBL_WR
   } psm_acc_t;
endpackage : psm_pkg

// [logic/psm_byte_lane.sv]
// Purpose: steers a program word into the 16-bit data result
// Assumes: hi selects the upper program byte column
// Notes:   combinational
`timescale 1ns/1ns
module psm_byte_lane (
   input  wire logic [23:0] pword,
   input  wire logic        hi,
   input  wire logic        byte_mode,
   input  wire logic        bsel,
   output logic      [15:0] dout
);
   always_comb begin
      dout = 16'h0000;
      if (!hi) begin
         if (!byte_mode) begin
            dout = pword[15:0]; // [R1]
         end else begin
            dout = {8'h00, bsel ? pword[15:8] : pword[7:0]}; // [R2]
         end
      end else begin
         if (!byte_mode) begin
            dout = {8'h00, pword[23:16]}; // [R3]
         end else begin
            dout = {8'h00, bsel ? 8'h00 : pword[23:16]}; // [R4]
         end
      end
   end
endmodule : psm_byte_lane

// [logic/psm_cycle_cost.sv]
// Purpose: extra instruction cycles for a visibility-window access
// Assumes: sequencer flags the loop context
// Notes:   combinational
`timescale 1ns/1ns
module psm_cycle_cost (
   input  wire logic       win,
   input  wire logic       is_mov,
   input  wire logic       in_rep,
   input  wire logic       rep_edge,
   output logic      [1:0] extra
);
   always_comb begin
      extra = psm_pkg::XTRA_NONE;
      if (win) begin
         if (!in_rep) begin
            extra = is_mov ? psm_pkg::XTRA_MOV : psm_pkg::XTRA_OTHER; // [R15]
         end else if (rep_edge) begin
            extra = psm_pkg::XTRA_OTHER; // [R16]
         end
      end
   end
endmodule : psm_cycle_cost

// [logic/psm_top.sv]
// Behaviour
// [R1] word low read returns bits 15:0
// [R2] byte low read picks byte by select
// [R3] word high read gives bits 23:16, zero top
// [R4] byte high read, phantom byte reads zero
// [R5] program counter steps two per word
// [R6] table page bit 7 picks config space
// [R7] config space refuses table writes
// [R8] window needs address msb and page bit 9
// [R9] window address is page low byte, ea[14:0]
// [R10] page bit 8 picks upper word half
// [R11] pages 200h-3ffh valid, halves split at 300h
// [R12] upper data half maps any 32k page
// [R13] zero page above 8000h traps
// [R14] window accesses are read-only
// [R15] outside loop one or two extra cycles
// [R16] loop edges cost two, others none
// [R17] table address is page then ea
// [R18] ea bit 0 selects byte
//
// Purpose: maps core loads onto 24-bit program memory
// Assumes: program memory answers one cycle after a request
// Notes:   registers over ahb-lite, one level interrupt
`timescale 1ns/1ns
module psm_top (
   input  wire logic        CLK_SYS,
   input  wire logic        RST_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        ACC_REQ,
   input  wire logic [1:0]  ACC_KIND,
   input  wire logic [15:0] ACC_EA,
   input  wire logic        ACC_BYTE,
   input  wire logic        ACC_WRITE,
   input  wire logic        ACC_IS_MOV,
   input  wire logic        ACC_IN_REP,
   input  wire logic        ACC_REP_EDGE,
   input  wire logic [22:0] PC_WORD_IDX,
   output logic      [23:0] PC_ADDR,
   output logic             PM_REQ,
   output logic      [23:0] PM_ADDR,
   input  wire logic [23:0] PM_RDATA,
   output logic             ACC_DONE,
   output logic      [15:0] ACC_RDATA,
   output logic             ACC_PASS,
   output logic             ACC_TRAP,
   output logic      [1:0]  ACC_EXTRA,
   output logic             IRQ
);
   typedef enum logic [1:0] {
      S_IDLE,
      S_WAIT,
      S_RESP
   } psm_state_t;

   psm_state_t  state_q;
   localparam int NUM_EVT_W = psm_pkg::NUM_EVT;
   logic [7:0]  tbl_page_q;
   logic [9:0]  rdpag_q;
   logic [NUM_EVT_W-1:0] status_q;
   logic [NUM_EVT_W-1:0] mask_q;
   logic [23:0] last_addr_q;
   logic [15:0] last_data_q;
   logic [15:0] cycles_q;
   logic        hi_q;
   logic        byte_q;
   logic        bsel_q;
   logic [15:0] lane_out;
   logic [1:0]  extra;
   logic [NUM_EVT_W-1:0] evt;

   // bus signals
   logic        b_wr_q;
   logic        b_rd_q;
   logic [7:0]  b_addr_q;
   logic        b_go;
   logic [31:0] rd_mux;

   // access decode
   psm_pkg::psm_acc_t kind;
   logic        is_tbl;
   logic        win_hit;
   logic        pg_zero;
   logic        trap;
   logic        cfg_wr;
   logic        win_wr;
   logic        hi_sel;
   logic [23:0] maddr;

   assign kind    = psm_pkg::psm_acc_t'(ACC_KIND);
   assign is_tbl  = (kind != psm_pkg::ACC_DATA);
   assign pg_zero = (rdpag_q == 10'h000);
   // window only on the upper 32 kbytes and enabled page
   assign win_hit = !is_tbl && ACC_EA[15] && rdpag_q[psm_pkg::RD_EN_BIT]; // [R8] [R12]
   // zero page above the window base traps
   assign trap    = !is_tbl && (ACC_EA >= psm_pkg::WIN_BASE) && pg_zero; // [R13]
   // table write into config space is dropped
   assign cfg_wr  = (kind == psm_pkg::ACC_TBL_WR) && tbl_page_q[psm_pkg::TBL_CFG_BIT]; // [R6] [R7]
   // writes through the window are refused
   assign win_wr  = win_hit && ACC_WRITE; // [R14]
   assign hi_sel  = (kind == psm_pkg::ACC_TBL_HI) ||
                    (win_hit && rdpag_q[psm_pkg::RD_HI_BIT]); // [R10] [R11]

   always_comb begin
      maddr = 24'h00_0000;
      if (is_tbl) begin
         maddr = {tbl_page_q, ACC_EA}; // [R17]
      end else if (win_hit) begin
         // pages 200h-2ffh and 300h-3ffh share address, bit 8 picks the half
         maddr = {1'b0, rdpag_q[7:0], ACC_EA[14:0]}; // [R9] [R11]
      end
   end

   // pc byte address is twice the word index
   assign PC_ADDR = {PC_WORD_IDX, 1'b0}; // [R5]

   psm_byte_lane u_lane (
      .pword     (PM_RDATA),
      .hi        (hi_q),
      .byte_mode (byte_q),
      .bsel      (bsel_q),
      .dout      (lane_out)
   );

   psm_cycle_cost u_cost (
      .win      (win_hit),
      .is_mov   (ACC_IS_MOV),
      .in_rep   (ACC_IN_REP),
      .rep_edge (ACC_REP_EDGE),
      .extra    (extra)
   );

   // access sequencer
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         state_q  <= S_IDLE;
         PM_REQ   <= 1'b0;
         PM_ADDR  <= 24'h00_0000;
         hi_q     <= 1'b0;
         byte_q   <= 1'b0;
         bsel_q   <= 1'b0;
         ACC_DONE <= 1'b0;
         ACC_PASS <= 1'b0;
         ACC_TRAP <= 1'b0;
         ACC_EXTRA <= 2'h0;
         ACC_RDATA <= 16'h0000;
      end else begin
         ACC_DONE <= 1'b0;
         ACC_TRAP <= 1'b0;
         PM_REQ   <= 1'b0;
         unique case (state_q)
            S_IDLE: begin
               if (ACC_REQ) begin
                  ACC_EXTRA <= extra;
                  if (trap) begin
                     ACC_TRAP <= 1'b1; // [R13]
                     ACC_DONE <= 1'b1;
                     ACC_PASS <= 1'b0;
                  end else if (is_tbl || win_hit) begin
                     if (cfg_wr || win_wr || kind == psm_pkg::ACC_TBL_WR) begin
                        // table writes belong to flash logic; here only refused
                        ACC_DONE <= 1'b1;
                        ACC_PASS <= 1'b0; // [R7] [R14]
                     end else begin
                        PM_REQ   <= 1'b1;
                        PM_ADDR  <= maddr;
                        hi_q     <= hi_sel;
                        byte_q   <= ACC_BYTE;
                        bsel_q   <= ACC_EA[0]; // [R18]
                        ACC_PASS <= 1'b1;
                        state_q  <= S_WAIT;
                     end
                  end else begin
                     ACC_DONE <= 1'b1;
                     ACC_PASS <= 1'b0;
                  end
               end
            end
            S_WAIT: begin
               state_q <= S_RESP;
            end
            S_RESP: begin
               ACC_RDATA <= lane_out; // [R1] [R2] [R3] [R4]
               ACC_DONE  <= 1'b1;
               state_q   <= S_IDLE;
            end
         endcase
      end
   end

   // observability registers
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         last_addr_q <= 24'h00_0000;
         last_data_q <= 16'h0000;
         cycles_q    <= 16'h0000;
      end else begin
         if (PM_REQ) begin
            last_addr_q <= PM_ADDR;
         end
         if (state_q == S_RESP) begin
            last_data_q <= lane_out;
         end
         if (ACC_REQ && state_q == S_IDLE && extra != psm_pkg::XTRA_NONE) begin
            cycles_q <= cycles_q + 16'(extra); // [R15] [R16]
         end
      end
   end

   // events
   assign evt[psm_pkg::ST_ADDRERR] = ACC_REQ && state_q == S_IDLE && trap;
   assign evt[psm_pkg::ST_CFGWR]   = ACC_REQ && state_q == S_IDLE && !trap && (cfg_wr || win_wr);
   assign evt[psm_pkg::ST_DONE]    = (state_q == S_RESP);

   // ahb-lite slave, zero wait states
   assign b_go      = HSEL && HREADY && HTRANS[1];
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         b_wr_q   <= 1'b0;
         b_rd_q   <= 1'b0;
         b_addr_q <= 8'h00;
      end else begin
         b_wr_q   <= b_go && HWRITE;
         b_rd_q   <= b_go && !HWRITE;
         b_addr_q <= HADDR[7:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         tbl_page_q <= psm_pkg::TBL_PAGE_RST;
         rdpag_q    <= psm_pkg::RDPAG_RST;
         mask_q     <= '0;
      end else if (b_wr_q) begin
         if (b_addr_q == psm_pkg::OFF_TBL_PAGE) begin
            tbl_page_q <= HWDATA[7:0];
         end
         if (b_addr_q == psm_pkg::OFF_RDPAG) begin
            rdpag_q <= HWDATA[9:0];
         end
         if (b_addr_q == psm_pkg::OFF_MASK) begin
            mask_q <= HWDATA[NUM_EVT_W-1:0];
         end
      end
   end

   // sticky status, set wins over write-one-to-clear
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         status_q <= '0;
      end else if (b_wr_q && b_addr_q == psm_pkg::OFF_STATUS) begin
         status_q <= (status_q & ~HWDATA[NUM_EVT_W-1:0]) | evt;
      end else begin
         status_q <= status_q | evt;
      end
   end

   assign IRQ = |(status_q & mask_q);

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (b_addr_q)
         psm_pkg::OFF_TBL_PAGE: rd_mux = {24'h00_0000, tbl_page_q};
         psm_pkg::OFF_RDPAG:    rd_mux = {22'h00_0000, rdpag_q};
         psm_pkg::OFF_STATUS:   rd_mux = {29'h0000_0000, status_q};
         psm_pkg::OFF_MASK:     rd_mux = {29'h0000_0000, mask_q};
         psm_pkg::OFF_LASTADDR: rd_mux = {8'h00, last_addr_q};
         psm_pkg::OFF_LASTDATA: rd_mux = {16'h0000, last_data_q};
         psm_pkg::OFF_CYCLES:   rd_mux = {16'h0000, cycles_q};
         default:               rd_mux = 32'h0000_0000;
      endcase
   end

   assign HRDATA = b_rd_q ? rd_mux : 32'h0000_0000;
endmodule : psm_top

// [dv/psm_pm_model.sv]
// Purpose: program memory stand-in for psm_top
// Assumes: word data is a fixed scramble of its address
// Notes:   data valid one cycle after a request, toggling otherwise
`timescale 1ns/1ns
module psm_pm_model (
   input  wire logic        CLK_SYS,
   input  wire logic        PM_REQ,
   input  wire logic [23:0] PM_ADDR,
   output logic      [23:0] PM_RDATA
);
   logic [23:0] addr_q;
   logic        vld_q;
   logic        tog_q = 1'b0;
   always @(posedge CLK_SYS) begin
      vld_q <= PM_REQ;
      tog_q <= ~tog_q;
      if (PM_REQ) begin
         addr_q <= PM_ADDR;
      end
   end
   // stale data never lingers on the bus
   assign PM_RDATA = vld_q ? {addr_q[7:0] ^ 8'h5A, addr_q[15:0] ^ 16'h1234} : {24{tog_q}};
endmodule : psm_pm_model

// [dv/psm_chk.sv]
// Purpose: port assertions for psm_top
// Assumes: one clock, sync active-low reset
// Notes:   bound below
`timescale 1ns/1ns
module psm_chk (
   input wire logic        CLK_SYS,
   input wire logic        RST_N,
   input wire logic [1:0]  ACC_KIND,
   input wire logic [15:0] ACC_EA,
   input wire logic        ACC_BYTE,
   input wire logic        ACC_IS_MOV,
   input wire logic        ACC_IN_REP,
   input wire logic        ACC_REP_EDGE,
   input wire logic [22:0] PC_WORD_IDX,
   input wire logic [23:0] PC_ADDR,
   input wire logic        PM_REQ,
   input wire logic [23:0] PM_ADDR,
   input wire logic [23:0] PM_RDATA,
   input wire logic        ACC_DONE,
   input wire logic [15:0] ACC_RDATA,
   input wire logic        ACC_TRAP,
   input wire logic [1:0]  ACC_EXTRA
);
   logic [23:0] pmd_q;
   logic [21:0] c_q;
   always_ff @(posedge CLK_SYS) begin
      pmd_q <= PM_RDATA;
      c_q   <= {ACC_KIND, ACC_EA, ACC_BYTE, ACC_IS_MOV, ACC_IN_REP, ACC_REP_EDGE};
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   pc_step_a: assert property (PC_ADDR == {PC_WORD_IDX, 1'b0})
      else $error("pc address wrong");
   tbl_addr_a: assert property (PM_REQ && !c_q[21] |-> PM_ADDR[15:0] == c_q[19:4])
      else $error("table address wrong");
   rd_time_a: assert property (PM_REQ |=> !PM_REQ ##1 ACC_DONE)
      else $error("read done late");
   lo_word_a: assert property (PM_REQ && c_q[21:20] == 2'h0 && !c_q[3]
      |-> ##2 ACC_RDATA == pmd_q[15:0])
      else $error("low word data wrong");
   hi_word_a: assert property (PM_REQ && c_q[21:20] == 2'h1 && !c_q[3]
      |-> ##2 ACC_RDATA == {8'h00, pmd_q[23:16]})
      else $error("high word data wrong");
   trap_end_a: assert property (ACC_TRAP |-> ACC_DONE ##1 !ACC_DONE && !ACC_TRAP)
      else $error("trap without single done");
   mov_cost_a: assert property (PM_REQ && c_q[21:20] == 2'h2 && c_q[2] && !c_q[1]
      |-> ##3 ACC_EXTRA == psm_pkg::XTRA_MOV)
      else $error("move cost wrong");
   rep_cost_a: assert property (PM_REQ && c_q[21:20] == 2'h2 && c_q[1] && !c_q[0]
      |-> ##3 ACC_EXTRA == psm_pkg::XTRA_NONE)
      else $error("loop cost wrong");
endmodule : psm_chk
bind psm_top psm_chk u_chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .ACC_KIND(ACC_KIND),
   .ACC_EA(ACC_EA), .ACC_BYTE(ACC_BYTE), .ACC_IS_MOV(ACC_IS_MOV), .ACC_IN_REP(ACC_IN_REP),
   .ACC_REP_EDGE(ACC_REP_EDGE), .PC_WORD_IDX(PC_WORD_IDX), .PC_ADDR(PC_ADDR),
   .PM_REQ(PM_REQ), .PM_ADDR(PM_ADDR), .PM_RDATA(PM_RDATA), .ACC_DONE(ACC_DONE),
   .ACC_RDATA(ACC_RDATA), .ACC_TRAP(ACC_TRAP), .ACC_EXTRA(ACC_EXTRA));

// [dv/tb_psm_top.sv]
// Purpose: self-checking bench for psm_top
// Assumes: zero-wait ahb-lite slave, model answers next cycle
// Notes:   f of acc is {byte, write, mov, rep, edge}
`timescale 1ns/1ns
module tb_psm_top;
   logic        CLK_SYS, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, IRQ, trap;
   logic        ACC_REQ, ACC_BYTE, ACC_WRITE, ACC_IS_MOV, ACC_IN_REP, ACC_REP_EDGE;
   logic        PM_REQ, ACC_DONE, ACC_PASS, ACC_TRAP;
   logic [31:0] HADDR, HWDATA, HRDATA, rd;
   logic [1:0]  HTRANS, ACC_KIND, ACC_EXTRA, k;
   logic [2:0]  HSIZE;
   logic [15:0] ACC_EA, ACC_RDATA, ea, e;
   logic [22:0] PC_WORD_IDX;
   logic [23:0] PC_ADDR, PM_ADDR, PM_RDATA, p;
   int          errors, n_checks, cyc;
   psm_top DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
      .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACC_REQ(ACC_REQ),
      .ACC_KIND(ACC_KIND), .ACC_EA(ACC_EA), .ACC_BYTE(ACC_BYTE), .ACC_WRITE(ACC_WRITE),
      .ACC_IS_MOV(ACC_IS_MOV), .ACC_IN_REP(ACC_IN_REP), .ACC_REP_EDGE(ACC_REP_EDGE),
      .PC_WORD_IDX(PC_WORD_IDX), .PC_ADDR(PC_ADDR), .PM_REQ(PM_REQ), .PM_ADDR(PM_ADDR),
      .PM_RDATA(PM_RDATA), .ACC_DONE(ACC_DONE), .ACC_RDATA(ACC_RDATA), .ACC_PASS(ACC_PASS),
      .ACC_TRAP(ACC_TRAP), .ACC_EXTRA(ACC_EXTRA), .IRQ(IRQ));
   psm_pm_model u_pm (.CLK_SYS(CLK_SYS), .PM_REQ(PM_REQ), .PM_ADDR(PM_ADDR),
      .PM_RDATA(PM_RDATA));
   function automatic logic [23:0] pw(input logic [23:0] a);
      return {a[7:0] ^ 8'h5A, a[15:0] ^ 16'h1234};
   endfunction : pw
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK_SYS);
      HSEL   <= 1'b1;
      HTRANS <= 2'b10;
      HADDR  <= {24'h00_0000, a};
      HWRITE <= w;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      HSEL   <= 1'b0;
      HTRANS <= 2'b00;
      HWDATA <= d;
      do @(posedge CLK_SYS); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
      chk("okay response", HRESP, 1'b0);
   endtask : bus
   task automatic acc(input logic [1:0] kd, input logic [15:0] a, input logic [4:0] f);
      @(posedge CLK_SYS);
      ACC_REQ  <= 1'b1;
      ACC_KIND <= kd;
      ACC_EA   <= a;
      {ACC_BYTE, ACC_WRITE, ACC_IS_MOV, ACC_IN_REP, ACC_REP_EDGE} <= f;
      @(posedge CLK_SYS);
      ACC_REQ <= 1'b0;
      repeat (8) begin
         #1;
         if (ACC_DONE === 1'b1) break;
         @(posedge CLK_SYS);
      end
      trap = ACC_TRAP;
      chk("access done", ACC_DONE, 1'b1);
   endtask : acc
   task automatic close_out;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : close_out
   initial begin
      CLK_SYS = 1'b0;
      forever #20 CLK_SYS = ~CLK_SYS;
   end
   always @(posedge CLK_SYS) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   initial begin
      {HSEL, HWRITE, ACC_REQ, ACC_BYTE, ACC_WRITE, ACC_IS_MOV, ACC_IN_REP, ACC_REP_EDGE} = '0;
      {HADDR, HWDATA, HTRANS, ACC_KIND, ACC_EA} = '0;
      HSIZE = 3'b010;
      PC_WORD_IDX = 23'h40_1235;
      RST_N = 1'b0;
      repeat (16) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      bus(0, psm_pkg::OFF_RDPAG, 0);
      chk("read page reset", rd, 32'h0000_0001);
      chk("pc address", {8'h00, PC_ADDR}, 32'h0080_246A);
      bus(1, psm_pkg::OFF_TBL_PAGE, 32'h0000_0012);
      bus(0, 8'h40, 0);
      chk("unmapped", rd, 32'h0000_0000);
      for (int i = 0; i < 6; i++) begin
         k  = (i < 3) ? 2'h0 : 2'h1;
         ea = 16'h4566 + ((i % 3 == 2) ? 16'h0001 : 16'h0000);
         acc(k, ea, {(i % 3) != 0, 4'h0});
         p = pw({8'h12, ea});
         e = k[0] ? {8'h00, p[23:16]} : ((i % 3) == 0) ? p[15:0]
             : {8'h00, ea[0] ? p[15:8] : p[7:0]};
         if (k[0] && ea[0]) e = 16'h0000;
         chk("table read", ACC_RDATA, e);
      end
      bus(1, psm_pkg::OFF_TBL_PAGE, 32'h0000_0080);
      acc(0, 16'h0102, 0);
      p = pw(24'h80_0102);
      chk("config read", ACC_RDATA, p[15:0]);
      acc(3, 16'h0102, 0);
      bus(0, psm_pkg::OFF_STATUS, 0);
      chk("config write refused", rd & 32'h2, 32'h0000_0002);
      bus(1, psm_pkg::OFF_STATUS, 32'h0000_0007);
      bus(1, psm_pkg::OFF_RDPAG, 32'h0000_0202);
      acc(2, 16'h800A, 5'b00100);
      p = pw(24'h01_000A);
      chk("window low", ACC_RDATA, p[15:0]);
      chk("move cost", ACC_EXTRA, psm_pkg::XTRA_MOV);
      bus(1, psm_pkg::OFF_RDPAG, 32'h0000_0302);
      acc(2, 16'hFFFE, 5'b00000);
      p = pw(24'h01_7FFE);
      chk("window high", ACC_RDATA, {8'h00, p[23:16]});
      chk("other cost", ACC_EXTRA, psm_pkg::XTRA_OTHER);
      acc(2, 16'h8000, 5'b00111);
      chk("loop edge cost", ACC_EXTRA, psm_pkg::XTRA_OTHER);
      acc(2, 16'h8000, 5'b00110);
      chk("loop cost", ACC_EXTRA, psm_pkg::XTRA_NONE);
      bus(0, psm_pkg::OFF_CYCLES, 0);
      chk("extra cycles", rd, 32'h0000_0005);
      bus(0, psm_pkg::OFF_LASTADDR, 0);
      chk("last address", rd, 32'h0001_0000);
      bus(0, psm_pkg::OFF_LASTDATA, 0);
      p = pw(24'h01_0000);
      chk("last data", rd, {24'h00_0000, p[23:16]});
      acc(2, 16'h7FFE, 0);
      chk("low half no window", ACC_PASS, 1'b0);
      acc(2, 16'h8002, 5'b01000);
      bus(0, psm_pkg::OFF_STATUS, 0);
      chk("window write refused", rd & 32'h2, 32'h0000_0002);
      bus(1, psm_pkg::OFF_MASK, 32'h0000_0001);
      bus(1, psm_pkg::OFF_RDPAG, 32'h0000_0000);
      acc(2, 16'h8000, 0);
      chk("zero page trap", trap, 1'b1);
      bus(0, psm_pkg::OFF_STATUS, 0);
      chk("trap status", rd & 32'h1, 32'h0000_0001);
      chk("irq raised", IRQ, 1'b1);
      bus(1, psm_pkg::OFF_MASK, 32'h0000_0000);
      bus(0, psm_pkg::OFF_MASK, 0);
      chk("irq masked", IRQ, 1'b0);
      bus(1, psm_pkg::OFF_STATUS, 32'h0000_0007);
      bus(0, psm_pkg::OFF_STATUS, 0);
      chk("status cleared", rd, 32'h0000_0000);
      PC_WORD_IDX <= 23'h7F_FFFF;
      @(posedge CLK_SYS);
      chk("pc address top", {8'h00, PC_ADDR}, 32'h00FF_FFFE);
      close_out();
   end
endmodule : tb_psm_top
